//--- common/nibble_alu_pkg.sv
// constants and types for the nibble accumulator datapath
// shared by the core and by whoever drives its request port
package nibble_alu_pkg;

	localparam int NIB_W      = 4;
	localparam int ROM_W      = 10;
	localparam int PAGE_W     = 2;
	localparam int PTR_W      = 8;
	localparam int ADDR_W     = PAGE_W + PTR_W;
	localparam int SLOT_W     = 2;
	localparam int LATCH_N    = 8;
	localparam int LATCH_W    = LATCH_N * NIB_W;
	localparam int ROM_HI_LSB = 4;
	localparam int ROM_LO_LSB = 0;
	localparam int IMM_HI_LSB = 5;
	localparam int IMM_LO_LSB = 0;

	localparam logic [3:0]  ACC_RST   = 4'h0;
	localparam logic        CARRY_RST = 1'h0;
	localparam logic [31:0] LATCH_RST = 32'h0;
	localparam logic [9:0]  ADDR_RST  = 10'h0;

	typedef enum logic [4:0] {
		OP_NOP      = 5'h00,
		OP_OR_REG   = 5'h01,
		OP_OR_ROM   = 5'h02,
		OP_OR_IMM   = 5'h03,
		OP_XOR_REG  = 5'h04,
		OP_XOR_ROM  = 5'h05,
		OP_XOR_IMM  = 5'h06,
		OP_INC      = 5'h07,
		OP_ROT      = 5'h08,
		OP_ROT_RST  = 5'h09,
		OP_IN       = 5'h0A,
		OP_OUT      = 5'h0B,
		OP_AND_PORT = 5'h0C,
		OP_OR_PORT  = 5'h0D,
		OP_XOR_PORT = 5'h0E,
		OP_OUT_IMM  = 5'h0F,
		OP_MOV_REG  = 5'h10,
		OP_MOV_ROM  = 5'h11,
		OP_MOV_IMM  = 5'h12
	} op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_EXEC = 2'h2
	} state_t;

endpackage

//--- core/nibble_alu_core.sv
// nibble accumulator datapath: logic, port and load instructions
// assumes the decoder presents one request with its operands and
// holds page/pointer steady; the program memory reads asynchronously
`timescale 1ns/1ps
`default_nettype none

module nibble_alu_core (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        reset,
	// request from the decoder
	input  wire logic        exec_valid,
	input  wire logic [4:0]  exec_op,
	input  wire logic [3:0]  reg_rdata,
	input  wire logic        nibble_high_sel,
	input  wire logic        port_bank,
	input  wire logic [2:0]  port_num,
	input  wire logic [9:0]  imm_word,
	input  wire logic [1:0]  rom_page_register,
	input  wire logic [7:0]  pointer_pair,
	// program memory
	output logic      [9:0]  rom_addr,
	input  wire logic [9:0]  rom_rdata,
	// port nibbles, index {bank, slot}
	input  wire logic [31:0] port_pins,
	output logic      [31:0] port_latch,
	// state and status
	output logic      [3:0]  acc,
	output logic             carry_flag,
	output logic             exec_busy,
	output logic             exec_done,
	output logic             core_reset_req
);

	typedef struct packed {
		nibble_alu_pkg::state_t state;
		nibble_alu_pkg::op_t    op;
		logic [3:0]             acc;
		logic                   carry;
		logic [9:0]             addr;
		logic [3:0]             reg_val;
		logic [9:0]             imm;
		logic                   nib_high;
		logic                   bank;
		logic [1:0]             slot;
		logic                   slot_ok;
		logic [31:0]            latch;
		logic [31:0]            pin_meta;
		logic [31:0]            pin_sync;
		logic                   busy;
		logic                   done;
		logic                   rst_req;
	} dp_t;

	dp_t        s_q;
	dp_t        s_d;
	logic [3:0] rom_nib;
	logic [3:0] pin_nib;
	logic [3:0] imm_nib;
	logic [4:0] lat_lsb;
	logic [4:0] hi_lsb;
	logic [4:0] lo_lsb;

	// only the chosen nibble of the ten-bit word is used
	assign rom_nib = s_q.nib_high ? rom_rdata[nibble_alu_pkg::ROM_HI_LSB +: 4]
	                              : rom_rdata[nibble_alu_pkg::ROM_LO_LSB +: 4];
	assign imm_nib = s_q.imm[nibble_alu_pkg::IMM_LO_LSB +: 4];
	assign lat_lsb = {s_q.bank, s_q.slot, 2'h0};
	assign hi_lsb  = {1'h1, s_q.slot, 2'h0};
	assign lo_lsb  = {1'h0, s_q.slot, 2'h0};
	assign pin_nib = s_q.pin_sync[lat_lsb +: 4];

	always_comb begin
		s_d          = s_q;
		s_d.pin_meta = port_pins;
		// first stage read by the second stage only
		s_d.pin_sync = s_q.pin_meta;
		s_d.done     = 1'h0;
		s_d.rst_req  = 1'h0;
		case (s_q.state)
			nibble_alu_pkg::ST_IDLE: begin
				if (exec_valid) begin
					s_d.op       = nibble_alu_pkg::op_t'(exec_op);
					s_d.reg_val  = reg_rdata;
					s_d.imm      = imm_word;
					s_d.nib_high = nibble_high_sel;
					s_d.bank     = port_bank;
					s_d.addr     = {rom_page_register, pointer_pair};
					// ports 2 and above 4 are not fitted: such requests do nothing
					case (port_num)
						3'h0: begin
							s_d.slot    = 2'h0;
							s_d.slot_ok = 1'h1;
						end
						3'h1: begin
							s_d.slot    = 2'h1;
							s_d.slot_ok = 1'h1;
						end
						3'h3: begin
							s_d.slot    = 2'h2;
							s_d.slot_ok = 1'h1;
						end
						3'h4: begin
							s_d.slot    = 2'h3;
							s_d.slot_ok = 1'h1;
						end
						default: begin
							s_d.slot    = 2'h0;
							s_d.slot_ok = 1'h0;
						end
					endcase
					s_d.busy  = 1'h1;
					s_d.state = nibble_alu_pkg::ST_EXEC;
				end
			end
			nibble_alu_pkg::ST_EXEC: begin
				// carry holds unless the operation names it
				case (s_q.op)
					nibble_alu_pkg::OP_OR_REG: begin
						s_d.acc   = s_q.acc | s_q.reg_val;
						s_d.carry = 1'h0;
					end
					nibble_alu_pkg::OP_OR_ROM: begin
						s_d.acc   = s_q.acc | rom_nib;
						s_d.carry = 1'h0;
					end
					nibble_alu_pkg::OP_OR_IMM: begin
						s_d.acc   = s_q.acc | imm_nib;
						s_d.carry = 1'h0;
					end
					nibble_alu_pkg::OP_XOR_REG: begin
						s_d.acc   = s_q.acc ^ s_q.reg_val;
						s_d.carry = s_q.acc[3] & s_q.reg_val[3];
					end
					nibble_alu_pkg::OP_XOR_ROM: begin
						s_d.acc   = s_q.acc ^ rom_nib;
						s_d.carry = s_q.acc[3] & rom_nib[3];
					end
					nibble_alu_pkg::OP_XOR_IMM: begin
						s_d.acc   = s_q.acc ^ imm_nib;
						s_d.carry = s_q.acc[3] & imm_nib[3];
					end
					nibble_alu_pkg::OP_INC: begin
						s_d.acc   = 4'(s_q.acc + 4'h1);
						s_d.carry = (s_q.acc == 4'hF);
					end
					nibble_alu_pkg::OP_ROT: begin
						s_d.acc   = {s_q.acc[2:0], s_q.acc[3]};
						s_d.carry = s_q.acc[3];
					end
					nibble_alu_pkg::OP_ROT_RST: begin
						// the reset itself belongs to the sequencer; we only ask
						if (s_q.acc == 4'h0) begin
							s_d.rst_req = 1'h1;
						end else begin
							s_d.acc   = {s_q.acc[2:0], s_q.acc[3]};
							s_d.carry = s_q.acc[3];
						end
					end
					nibble_alu_pkg::OP_IN: begin
						if (s_q.slot_ok) begin
							s_d.acc   = pin_nib;
							s_d.carry = 1'h0;
						end
					end
					nibble_alu_pkg::OP_OUT: begin
						if (s_q.slot_ok) begin
							s_d.latch[lat_lsb +: 4] = s_q.acc;
						end
					end
					nibble_alu_pkg::OP_AND_PORT: begin
						if (s_q.slot_ok) begin
							s_d.acc   = s_q.acc & pin_nib;
							s_d.carry = s_q.acc[3] & pin_nib[3];
						end
					end
					nibble_alu_pkg::OP_OR_PORT: begin
						if (s_q.slot_ok) begin
							s_d.acc   = s_q.acc | pin_nib;
							s_d.carry = 1'h0;
						end
					end
					nibble_alu_pkg::OP_XOR_PORT: begin
						if (s_q.slot_ok) begin
							s_d.acc   = s_q.acc ^ pin_nib;
							s_d.carry = s_q.acc[3] & pin_nib[3];
						end
					end
					nibble_alu_pkg::OP_OUT_IMM: begin
						if (s_q.slot_ok) begin
							s_d.latch[hi_lsb +: 4] = s_q.imm[nibble_alu_pkg::IMM_HI_LSB +: 4];
							s_d.latch[lo_lsb +: 4] = s_q.imm[nibble_alu_pkg::IMM_LO_LSB +: 4];
						end
					end
					nibble_alu_pkg::OP_MOV_REG: begin
						s_d.acc   = s_q.reg_val;
						s_d.carry = 1'h0;
					end
					nibble_alu_pkg::OP_MOV_ROM: begin
						s_d.acc   = rom_nib;
						s_d.carry = 1'h0;
					end
					nibble_alu_pkg::OP_MOV_IMM: begin
						s_d.acc   = imm_nib;
						s_d.carry = 1'h0;
					end
					default: begin
						s_d.acc = s_q.acc;
					end
				endcase
				s_d.done  = 1'h1;
				s_d.busy  = 1'h0;
				s_d.state = nibble_alu_pkg::ST_IDLE;
			end
			default: begin
				s_d.busy  = 1'h0;
				s_d.state = nibble_alu_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			s_q          <= '0;
			s_q.state    <= nibble_alu_pkg::ST_IDLE;
			s_q.op       <= nibble_alu_pkg::OP_NOP;
			s_q.acc      <= nibble_alu_pkg::ACC_RST;
			s_q.carry    <= nibble_alu_pkg::CARRY_RST;
			s_q.addr     <= nibble_alu_pkg::ADDR_RST;
			s_q.latch    <= nibble_alu_pkg::LATCH_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign rom_addr       = s_q.addr;
	assign port_latch     = s_q.latch;
	assign acc            = s_q.acc;
	assign carry_flag     = s_q.carry;
	assign exec_busy      = s_q.busy;
	assign exec_done      = s_q.done;
	assign core_reset_req = s_q.rst_req;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	logic fire;
	assign fire = (s_q.state == nibble_alu_pkg::ST_EXEC);

	or_reg_a: assert property (fire && s_q.op == nibble_alu_pkg::OP_OR_REG |=>
		acc == ($past(s_q.acc) | $past(s_q.reg_val)) && !carry_flag && exec_done)
		else $error("or with register wrong");
	or_rom_a: assert property (fire && s_q.op == nibble_alu_pkg::OP_OR_ROM && s_q.nib_high |=>
		acc == ($past(s_q.acc) | $past(rom_rdata[7:4])) && !carry_flag)
		else $error("or with memory high nibble wrong");
	xor_reg_a: assert property (fire && s_q.op == nibble_alu_pkg::OP_XOR_REG |=>
		acc == ($past(s_q.acc) ^ $past(s_q.reg_val)) && carry_flag == ($past(s_q.acc[3]) & $past(s_q.reg_val[3])))
		else $error("xor with register wrong");
	xor_imm_a: assert property (fire && s_q.op == nibble_alu_pkg::OP_XOR_IMM |=>
		carry_flag == ($past(s_q.acc[3]) & $past(s_q.imm[3])))
		else $error("xor immediate carry wrong");
	inc_wrap_a: assert property (fire && s_q.op == nibble_alu_pkg::OP_INC && s_q.acc == 4'hF |=>
		acc == 4'h0 && carry_flag)
		else $error("increment wrap wrong");
	rotate_a: assert property (fire && s_q.op == nibble_alu_pkg::OP_ROT |=>
		acc == {$past(s_q.acc[2:0]), $past(s_q.acc[3])} && carry_flag == $past(s_q.acc[3]))
		else $error("rotate wrong");
	zero_reset_a: assert property (fire && s_q.op == nibble_alu_pkg::OP_ROT_RST && s_q.acc == 4'h0 |=>
		core_reset_req && $stable(acc) ##1 !core_reset_req)
		else $error("rotate-or-reset request wrong");
	port_in_a: assert property (fire && s_q.op == nibble_alu_pkg::OP_IN && s_q.slot_ok |=>
		acc == $past(pin_nib) && !carry_flag)
		else $error("port input wrong");
	port_out_a: assert property (fire && s_q.op == nibble_alu_pkg::OP_OUT && s_q.slot_ok |=>
		port_latch[$past(lat_lsb) +: 4] == $past(s_q.acc))
		else $error("port output latch wrong");
	and_port_a: assert property (fire && s_q.op == nibble_alu_pkg::OP_AND_PORT && s_q.slot_ok |=>
		acc == ($past(s_q.acc) & $past(pin_nib)) && carry_flag == ($past(s_q.acc[3]) & $past(pin_nib[3])))
		else $error("and with port wrong");
	pair_out_a: assert property (fire && s_q.op == nibble_alu_pkg::OP_OUT_IMM && s_q.slot_ok |=>
		port_latch[$past(hi_lsb) +: 4] == $past(s_q.imm[8:5]) && port_latch[$past(lo_lsb) +: 4] == $past(s_q.imm[3:0]))
		else $error("port pair immediate wrong");
	addr_form_a: assert property (exec_valid && !exec_busy |=>
		rom_addr == $past({rom_page_register, pointer_pair}) && exec_busy ##1 exec_done && !exec_busy)
		else $error("request timing or address wrong");

	rot_reset_c: cover property (fire && s_q.op == nibble_alu_pkg::OP_ROT_RST && s_q.acc == 4'h0);
	pair_out_c:  cover property (fire && s_q.op == nibble_alu_pkg::OP_OUT_IMM && s_q.slot_ok);
	b2b_c:       cover property (exec_done ##0 exec_valid ##2 exec_done);

endmodule // nibble_alu_core

`default_nettype wire

//--- tb/program_rom_model.sv
// program memory stand-in: ten-bit words read without a clock
// assumes the core holds rom_addr steady through its execute cycle
`timescale 1ns/1ps
`default_nettype none

module program_rom_model #(
	parameter logic [9:0] ROM_KEY = 10'h2C9
) (
	// address from the core
	input  wire logic [9:0] rom_addr,
	// word back to the core
	output logic      [9:0] rom_rdata
);
	// every cell differs, so a wrong pointer bit shows at once; a wrong page bit flips only bits 9 and 8, which the core never reads
	assign rom_rdata = rom_addr ^ ROM_KEY;
endmodule // program_rom_model

`default_nettype wire

//--- tb/nibble_alu_port_transfer_exec_test.sv
// self-checking bench for the nibble accumulator datapath
// assumes a request is answered one cycle after it is taken
`timescale 1ns/1ps
`default_nettype none

module nibble_alu_port_transfer_exec_test;
	localparam logic [9:0] KEY = 10'h2C9;
	logic        mclk = 1'b0;
	logic        reset = 1'b1;
	logic        exec_valid = 1'b0;
	logic [4:0]  exec_op = 5'h00;
	logic [3:0]  reg_rdata = 4'h0;
	logic        nibble_high_sel = 1'b0;
	logic        port_bank = 1'b0;
	logic [2:0]  port_num = 3'h0;
	logic [9:0]  imm_word = 10'h000;
	logic [1:0]  rom_page_register = 2'h0;
	logic [7:0]  pointer_pair = 8'h00;
	logic [31:0] port_pins = 32'h0000_0000;
	logic [9:0]  rom_addr, rom_rdata;
	logic [31:0] port_latch;
	logic [3:0]  acc;
	logic        carry_flag, exec_busy, exec_done, core_reset_req;
	// expected state, kept from the documented behaviour
	logic [3:0]  ae = 4'h0;
	logic        ce = 1'b0;
	logic [31:0] le = 32'h0000_0000;
	int          num_errors = 0;
	int          tests_run = 0;

	always #5 mclk = ~mclk;

	nibble_alu_core nibble_alu_core_inst (.mclk(mclk), .reset(reset), .exec_valid(exec_valid),
		.exec_op(exec_op), .reg_rdata(reg_rdata), .nibble_high_sel(nibble_high_sel),
		.port_bank(port_bank), .port_num(port_num), .imm_word(imm_word),
		.rom_page_register(rom_page_register), .pointer_pair(pointer_pair), .rom_addr(rom_addr),
		.rom_rdata(rom_rdata), .port_pins(port_pins), .port_latch(port_latch), .acc(acc),
		.carry_flag(carry_flag), .exec_busy(exec_busy), .exec_done(exec_done),
		.core_reset_req(core_reset_req));

	program_rom_model #(.ROM_KEY(KEY)) program_rom_model_inst (.rom_addr(rom_addr), .rom_rdata(rom_rdata));

	// wide enough for the flag, accumulator and all latches in one compare
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one request, expectation worked out before it is taken
	task automatic go(input logic [4:0] o);
		logic [9:0] w;
		logic [3:0] mn, pn, im;
		logic [2:0] k;
		logic       pv, rr;
		w = {rom_page_register, pointer_pair} ^ KEY;
		mn = nibble_high_sel ? w[7:4] : w[3:0];
		im = imm_word[3:0];
		pv = port_num inside {3'h0, 3'h1, 3'h3, 3'h4};
		k = {port_bank, (port_num > 3'h2) ? port_num[1:0] - 2'h1 : port_num[1:0]};
		pn = port_pins[4*k +: 4];
		rr = 1'b0;
		case (o)
			nibble_alu_pkg::OP_OR_REG: {ae, ce} = {ae | reg_rdata, 1'b0};
			nibble_alu_pkg::OP_OR_ROM: {ae, ce} = {ae | mn, 1'b0};
			nibble_alu_pkg::OP_OR_IMM: {ae, ce} = {ae | im, 1'b0};
			nibble_alu_pkg::OP_XOR_REG: {ae, ce} = {ae ^ reg_rdata, ae[3] & reg_rdata[3]};
			nibble_alu_pkg::OP_XOR_ROM: {ae, ce} = {ae ^ mn, ae[3] & mn[3]};
			nibble_alu_pkg::OP_XOR_IMM: {ae, ce} = {ae ^ im, ae[3] & im[3]};
			nibble_alu_pkg::OP_INC: {ce, ae} = {ae == 4'hF, ae + 4'h1};
			nibble_alu_pkg::OP_ROT: {ae, ce} = {ae[2:0], ae[3], ae[3]};
			nibble_alu_pkg::OP_ROT_RST: if (ae == 4'h0) rr = 1'b1; else {ae, ce} = {ae[2:0], ae[3], ae[3]};
			nibble_alu_pkg::OP_IN: if (pv) {ae, ce} = {pn, 1'b0};
			nibble_alu_pkg::OP_OUT: if (pv) le[4*k +: 4] = ae;
			nibble_alu_pkg::OP_AND_PORT: if (pv) {ae, ce} = {ae & pn, ae[3] & pn[3]};
			nibble_alu_pkg::OP_OR_PORT: if (pv) {ae, ce} = {ae | pn, 1'b0};
			nibble_alu_pkg::OP_XOR_PORT: if (pv) {ae, ce} = {ae ^ pn, ae[3] & pn[3]};
			nibble_alu_pkg::OP_OUT_IMM: if (pv) le = le & ~(32'h000F_000F << 4*k[1:0])
				| ({12'h000, imm_word[8:5], 12'h000, im} << 4*k[1:0]);
			nibble_alu_pkg::OP_MOV_REG: {ae, ce} = {reg_rdata, 1'b0};
			nibble_alu_pkg::OP_MOV_ROM: {ae, ce} = {mn, 1'b0};
			nibble_alu_pkg::OP_MOV_IMM: {ae, ce} = {im, 1'b0};
			default: ;
		endcase
		@(posedge mclk);
		#1;
		exec_op = o;
		exec_valid = 1'b1;
		@(posedge mclk);
		#1;
		exec_valid = 1'b0;
		chk(exec_busy, 1'b1);
		chk(rom_addr, {rom_page_register, pointer_pair});
		@(posedge mclk);
		#1;
		chk(exec_done, 1'b1);
		chk(core_reset_req, rr);
		chk(acc, ae);
		chk(carry_flag, ce);
		chk(port_latch, le);
	endtask

	task automatic t_logic;
		imm_word = 10'h009;
		go(nibble_alu_pkg::OP_MOV_IMM);
		reg_rdata = 4'hC;
		go(nibble_alu_pkg::OP_XOR_REG);
		reg_rdata = 4'h2;
		go(nibble_alu_pkg::OP_OR_REG);
		imm_word = 10'h008;
		go(nibble_alu_pkg::OP_XOR_IMM);
		go(nibble_alu_pkg::OP_XOR_IMM);
		go(nibble_alu_pkg::OP_OR_IMM);
		go(nibble_alu_pkg::OP_INC);
		go(nibble_alu_pkg::OP_ROT_RST);
		imm_word = 10'h00B;
		go(nibble_alu_pkg::OP_MOV_IMM);
		go(nibble_alu_pkg::OP_ROT);
		go(nibble_alu_pkg::OP_ROT_RST);
		$display("test logic done, errors %0d", num_errors);
	endtask

	task automatic t_rom;
		// word at page 1, pointer 3C carries both bit 9 and bit 8 set
		rom_page_register = 2'h1;
		pointer_pair = 8'h3C;
		nibble_high_sel = 1'b1;
		go(nibble_alu_pkg::OP_MOV_ROM);
		nibble_high_sel = 1'b0;
		go(nibble_alu_pkg::OP_XOR_ROM);
		nibble_high_sel = 1'b1;
		go(nibble_alu_pkg::OP_XOR_ROM);
		nibble_high_sel = 1'b0;
		go(nibble_alu_pkg::OP_OR_ROM);
		go(nibble_alu_pkg::OP_MOV_ROM);
		rom_page_register = 2'h2;
		pointer_pair = 8'hA7;
		nibble_high_sel = 1'b1;
		go(nibble_alu_pkg::OP_OR_ROM);
		for (int i = 0; i < 16; i++) begin
			reg_rdata = 4'(15 - i);
			go(nibble_alu_pkg::OP_MOV_REG);
		end
		$display("test memory and transfer done, errors %0d", num_errors);
	endtask

	task automatic t_ports;
		port_pins = 32'h96E1_A5C3;
		// two-flop input synchroniser needs the pins settled first
		repeat (3) @(posedge mclk);
		for (int i = 0; i < 8; i++) begin
			port_bank = i[2];
			port_num = (i[1:0] > 2'h1) ? 3'(i[1:0] + 1) : 3'(i[1:0]);
			go(nibble_alu_pkg::OP_IN);
			go(nibble_alu_pkg::OP_INC);
			go(nibble_alu_pkg::OP_OUT);
			go(nibble_alu_pkg::OP_AND_PORT);
			go(nibble_alu_pkg::OP_OR_PORT);
			go(nibble_alu_pkg::OP_XOR_PORT);
			imm_word = 10'h1A5 ^ 10'(i);
			go(nibble_alu_pkg::OP_OUT_IMM);
		end
		port_num = 3'h2;
		go(nibble_alu_pkg::OP_OUT);
		go(nibble_alu_pkg::OP_IN);
		$display("test ports done, errors %0d", num_errors);
	endtask

	// strobe held through busy: refused once, taken again while done shows
	task automatic t_refuse;
		imm_word = 10'h003;
		go(nibble_alu_pkg::OP_MOV_IMM);
		@(posedge mclk);
		#1;
		exec_op = nibble_alu_pkg::OP_INC;
		exec_valid = 1'b1;
		@(posedge mclk);
		#1;
		chk(exec_busy, 1'b1);
		@(posedge mclk);
		#1;
		chk({exec_done, carry_flag, acc}, {1'b1, 1'b0, 4'h4});
		@(posedge mclk);
		#1;
		exec_valid = 1'b0;
		chk({exec_busy, acc}, {1'b1, 4'h4});
		@(posedge mclk);
		#1;
		chk({exec_done, carry_flag, acc}, {1'b1, 1'b0, 4'h5});
		ae = 4'h5;
		ce = 1'b0;
		$display("test back-to-back done, errors %0d", num_errors);
	endtask

	task automatic stop_test;
		$display("checks %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge mclk);
		#1;
		reset = 1'b0;
		chk({carry_flag, acc, port_latch}, 37'h0);
		t_logic;
		t_rom;
		t_ports;
		t_refuse;
		stop_test;
	end

	initial begin
		#50000;
		num_errors++;
		stop_test;
	end
endmodule // nibble_alu_port_transfer_exec_test

`default_nettype wire
